// ==== hw/dcs_regs.vh ====
`ifndef DCS_REGS_VH
`define DCS_REGS_VH

// Register byte offsets on the plain register port.
`define DCS_OFF_STATUS 8'h00
`define DCS_OFF_CLEAR 8'h04
`define DCS_OFF_ENABLE 8'h08
`define DCS_OFF_ERROR 8'h0C
`define DCS_OFF_PEND 8'h10

// Status bit positions, shared by status, clear and enable.
`define DCS_ST_COMMIT 0
`define DCS_ST_ERROR 1
`define DCS_ST_IMM 2
`define DCS_ST_W 3

// Deferred slots, numbered in commit order.
`define DCS_S_UTERM 5'h00
`define DCS_S_QTERM 5'h01
`define DCS_S_FMT 5'h02
`define DCS_S_SRQ 5'h03
`define DCS_S_EVT 5'h04
`define DCS_S_TLVL 5'h05
`define DCS_S_ALM 5'h06
`define DCS_S_ALMSTP 5'h07
`define DCS_S_DINSTP 5'h08
`define DCS_S_CHCFG 5'h09
`define DCS_S_CHCLR 5'h0A
`define DCS_S_RELAY 5'h0B
`define DCS_S_BURST 5'h0C
`define DCS_S_MMODE 5'h0D
`define DCS_S_AVG 5'h0E
`define DCS_S_TTIME 5'h0F
`define DCS_S_SCAN 5'h10
`define DCS_S_COUNT 5'h11
`define DCS_S_TCFG 5'h12
`define DCS_S_TRIG 5'h13
`define DCS_S_LAST 5'h13
`define DCS_NSLOT 20
`define DCS_S_IMM 5'h1E
`define DCS_S_BAD 5'h1F

// Error codes.
`define DCS_E_NONE 4'h0
`define DCS_E_SYNTAX 4'h1
`define DCS_E_CONFLICT 4'h4

// Character codes the decoder treats specially.
`define DCS_CH_SP 8'h20
`define DCS_CH_HASH 8'h23
`define DCS_CH_STAR 8'h2A
`define DCS_CH_COMMA 8'h2C
`define DCS_CH_DASH 8'h2D
`define DCS_CH_DOT 8'h2E
`define DCS_CH_0 8'h30
`define DCS_CH_9 8'h39
`define DCS_CH_COLON 8'h3A
`define DCS_CH_QMARK 8'h3F
`define DCS_CH_AT 8'h40
`define DCS_CH_A 8'h41
`define DCS_CH_C 8'h43
`define DCS_CH_E 8'h45
`define DCS_CH_Q 8'h51
`define DCS_CH_X 8'h58
`define DCS_CH_Z 8'h5A
`define DCS_CH_LA 8'h61
`define DCS_CH_LZ 8'h7A
`define DCS_CASE 8'h20
`define DCS_TEN 20'h0000A

`endif

// ==== hw/dcs_sequencer.v ====
`timescale 1ns/1ps
// Summary of operation
// - Interpret characters strictly in arrival order.
// - Immediates act now; deferred wait for commit.
// - Deferred effects are held in staging registers.
// - Repeated deferred command: last occurrence wins.
// - The commit command ends every line.
// - After error, skip through next commit.
// - Staged effects apply all together or none.
// - Fixed set of commands are deferred.
// - Fixed set of commands are immediate.
// - Nothing staged applies before commit parses.
// - Commit applies staged effects in fixed order.
// - Step seven applies the channel setup group.
// - Arrival order never changes commit order.
// - Acquisition enabled only after trigger configuration.
// - Letters accepted in upper or lower case.
// - Bad parameter raises conflict error code four.
`include "dcs_regs.vh"

module dcs_sequencer (
  // Clock and synchronous active-low reset.
  input wire clk,
  input wire rst_n,
  // Character stream from the link logic, same clock.
  input wire char_valid,
  input wire [7:0] char_data,
  output reg char_ready,
  // Immediate command effects.
  output reg imm_stb,
  output reg [11:0] imm_cmd,
  output reg [15:0] imm_val,
  // Deferred effects released at commit.
  output reg apply_stb,
  output reg [4:0] apply_slot,
  output reg [15:0] apply_val,
  output reg trig_stb,
  output reg acq_en,
  // Front panel error indicator.
  output reg err_led,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Level interrupt.
  output reg irq
);

  // Parser states.
  localparam ST_IDLE = 3'h0;
  localparam ST_STAR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_SKIP = 3'h3;
  localparam ST_COMMIT = 3'h4;

  // Folds a lower case letter onto its upper case code.
  function [7:0] dcs_upper;
    input [7:0] c;
    begin
      if (c >= `DCS_CH_LA && c <= `DCS_CH_LZ)
      begin
        dcs_upper = c - `DCS_CASE;
      end
      else
      begin
        dcs_upper = c;
      end
    end
  endfunction

  // True for an upper case letter.
  function dcs_is_let;
    input [7:0] c;
    begin
      dcs_is_let = (c >= `DCS_CH_A) && (c <= `DCS_CH_Z);
    end
  endfunction

  // Maps a command to its deferred slot, or to immediate or bad.
  function [4:0] dcs_slot;
    input st;
    input pd;
    input qc;
    input [7:0] c;
    begin
      case ({st, pd, c})
        10'h056: dcs_slot = `DCS_S_UTERM;
        10'h051: dcs_slot = qc ? `DCS_S_IMM : `DCS_S_QTERM;
        10'h046: dcs_slot = `DCS_S_FMT;
        10'h04D: dcs_slot = `DCS_S_SRQ;
        10'h04E: dcs_slot = `DCS_S_EVT;
        10'h04C: dcs_slot = `DCS_S_TLVL;
        10'h041: dcs_slot = `DCS_S_ALM;
        10'h141: dcs_slot = `DCS_S_ALMSTP;
        10'h149: dcs_slot = `DCS_S_DINSTP;
        10'h043: dcs_slot = `DCS_S_CHCFG;
        10'h243: dcs_slot = `DCS_S_CHCLR;
        10'h144: dcs_slot = `DCS_S_RELAY;
        10'h146: dcs_slot = `DCS_S_BURST;
        10'h14D: dcs_slot = `DCS_S_MMODE;
        10'h157: dcs_slot = `DCS_S_AVG;
        10'h050: dcs_slot = `DCS_S_TTIME;
        10'h049: dcs_slot = `DCS_S_SCAN;
        10'h059: dcs_slot = `DCS_S_COUNT;
        10'h054: dcs_slot = `DCS_S_TCFG;
        10'h040: dcs_slot = `DCS_S_TRIG;
        // Everything below acts as soon as it is interpreted.
        10'h242, 10'h246, 10'h24B, 10'h250, 10'h252,
        10'h253, 10'h254, 10'h143, 10'h045, 10'h047,
        10'h048, 10'h04A, 10'h04B, 10'h04F, 10'h052,
        10'h152, 10'h053, 10'h055, 10'h03F:
          dcs_slot = `DCS_S_IMM;
        default: dcs_slot = `DCS_S_BAD;
      endcase
    end
  endfunction

  // Parser state and the command being assembled.
  reg [2:0] state;
  reg [7:0] cur_c;
  reg cur_st;
  reg cur_pd;
  reg cur_q;
  reg cur_qc;
  reg cur_hv;
  reg cur_pdone;
  reg [15:0] cur_v;
  // Staging registers, one word and one pending bit per slot.
  reg [15:0] stg [0:`DCS_S_LAST];
  reg [`DCS_NSLOT-1:0] pend;
  // Commit walk pointer.
  reg [4:0] idx;
  // Last error code.
  reg [3:0] err_code;
  // One-cycle event pulses toward the status register.
  reg ev_commit;
  reg ev_err;
  reg ev_imm;
  // Sticky status and interrupt enable.
  reg [`DCS_ST_W-1:0] stat;
  reg [`DCS_ST_W-1:0] ien;

  // Character classification after case folding.
  wire take = char_valid & char_ready;
  wire [7:0] uc = dcs_upper(char_data);
  wire is_x = (uc == `DCS_CH_X);
  wire is_dig = (uc >= `DCS_CH_0) && (uc <= `DCS_CH_9);
  // Range and time punctuation ends the first numeric field.
  wire is_sep = (uc <= `DCS_CH_SP) || (uc == `DCS_CH_COMMA) ||
    (uc == `DCS_CH_DASH) || (uc == `DCS_CH_DOT) ||
    (uc == `DCS_CH_COLON);
  wire cur_let = dcs_is_let(cur_c);
  // Suffix characters that still belong to the current command.
  wire pd_suffix = cur_let && !cur_hv && !cur_pd && !cur_q &&
    (uc == `DCS_CH_HASH);
  wire q_suffix = cur_let && !cur_hv && !cur_q &&
    (uc == `DCS_CH_QMARK);
  wire qc_suffix = (cur_c == `DCS_CH_Q) && !cur_st && !cur_hv &&
    !cur_pd && !cur_qc && (uc == `DCS_CH_C);
  // Characters that open a new command.
  wire starter = (dcs_is_let(uc) && !is_x) || (uc == `DCS_CH_AT) ||
    (uc == `DCS_CH_QMARK) || (uc == `DCS_CH_STAR);
  wire [4:0] cur_slot = dcs_slot(cur_st, cur_pd, cur_qc, cur_c);
  // Decimal accumulation; anything past 16 bits is out of range.
  wire [19:0] acc = {4'h0, cur_v} * `DCS_TEN + {16'h0000, uc[3:0]};
  wire ovf = |acc[19:16];

  // Flags an error and discards the rest of the line.
  task dcs_fail;
    input [3:0] code;
    begin
      state <= ST_SKIP;
      err_code <= code;
      err_led <= 1'b1;
      ev_err <= 1'b1;
    end
  endtask

  // Error found on the commit character itself: line ends here.
  task dcs_abort;
    input [3:0] code;
    begin
      state <= ST_IDLE;
      err_code <= code;
      err_led <= 1'b1;
      ev_err <= 1'b1;
      pend <= {`DCS_NSLOT{1'b0}};
    end
  endtask

  // Opens a new command from the current character.
  task dcs_open;
    begin
      cur_st <= (uc == `DCS_CH_STAR);
      cur_c <= uc;
      cur_pd <= 1'b0;
      cur_q <= 1'b0;
      cur_qc <= 1'b0;
      cur_hv <= 1'b0;
      cur_pdone <= 1'b0;
      cur_v <= 16'h0000;
      state <= (uc == `DCS_CH_STAR) ? ST_STAR : ST_CMD;
    end
  endtask

  // Finishes a well-formed command: act now or stage it.
  task dcs_emit;
    begin
      if (cur_slot == `DCS_S_IMM)
      begin
        imm_stb <= 1'b1;
        imm_cmd <= {cur_st, cur_pd, cur_q, cur_qc, cur_c};
        ev_imm <= 1'b1;
        // The error query reports and then clears the indicator.
        // Only E? reports; other queries of immediates pass values.
        if (cur_q && cur_c == `DCS_CH_E)
        begin
          imm_val <= {12'h000, err_code};
          err_led <= 1'b0;
        end
        else
        begin
          imm_val <= cur_v;
        end
      end
      else
      begin
        // Overwriting the slot drops any earlier occurrence.
        stg[cur_slot] <= cur_v;
        pend[cur_slot] <= 1'b1;
      end
    end
  endtask

  // Starts the ordered walk over the staging slots.
  task dcs_commit;
    begin
      state <= ST_COMMIT;
      idx <= `DCS_S_UTERM;
      char_ready <= 1'b0;
    end
  endtask

  // Character parser and commit sequencer. One character per cycle
  // at most, taken in arrival order; input stalls during commit.
  always @(posedge clk)
  begin
    imm_stb <= 1'b0;
    apply_stb <= 1'b0;
    trig_stb <= 1'b0;
    ev_commit <= 1'b0;
    ev_err <= 1'b0;
    ev_imm <= 1'b0;
    if (!rst_n)
    begin
      state <= ST_IDLE;
      char_ready <= 1'b1;
      cur_c <= 8'h00;
      cur_st <= 1'b0;
      cur_pd <= 1'b0;
      cur_q <= 1'b0;
      cur_qc <= 1'b0;
      cur_hv <= 1'b0;
      cur_pdone <= 1'b0;
      cur_v <= 16'h0000;
      pend <= {`DCS_NSLOT{1'b0}};
      idx <= 5'h00;
      err_code <= `DCS_E_NONE;
      err_led <= 1'b0;
      imm_cmd <= 12'h000;
      imm_val <= 16'h0000;
      apply_slot <= 5'h00;
      apply_val <= 16'h0000;
      acq_en <= 1'b0;
    end
    else
    begin
      case (state)
        // Between commands: white space is skipped.
        ST_IDLE:
        begin
          if (take)
          begin
            if (is_x)
            begin
              dcs_commit;
            end
            else if (starter)
            begin
              dcs_open;
            end
            else if (!is_sep)
            begin
              dcs_fail(`DCS_E_SYNTAX);
            end
          end
        end
        // A star must be followed by a letter.
        ST_STAR:
        begin
          if (take)
          begin
            if (is_x)
            begin
              dcs_abort(`DCS_E_SYNTAX);
            end
            else if (dcs_is_let(uc))
            begin
              cur_c <= uc;
              state <= ST_CMD;
            end
            else
            begin
              dcs_fail(`DCS_E_SYNTAX);
            end
          end
        end
        // Collecting suffixes and the first numeric parameter.
        ST_CMD:
        begin
          if (take)
          begin
            if (pd_suffix)
            begin
              cur_pd <= 1'b1;
            end
            else if (qc_suffix)
            begin
              cur_qc <= 1'b1;
            end
            else if (q_suffix)
            begin
              cur_q <= 1'b1;
            end
            else if (is_dig)
            begin
              // Only the first field is kept; later ones pass by.
              if (!cur_pdone && ovf)
              begin
                dcs_fail(`DCS_E_CONFLICT);
              end
              else if (!cur_pdone)
              begin
                cur_v <= acc[15:0];
                cur_hv <= 1'b1;
              end
            end
            else if (is_sep)
            begin
              cur_pdone <= cur_hv;
            end
            else if (is_x || starter)
            begin
              if (cur_slot == `DCS_S_BAD && is_x)
              begin
                dcs_abort(`DCS_E_SYNTAX);
              end
              else if (cur_slot == `DCS_S_BAD)
              begin
                dcs_fail(`DCS_E_SYNTAX);
              end
              else
              begin
                dcs_emit;
                if (is_x)
                begin
                  dcs_commit;
                end
                else
                begin
                  dcs_open;
                end
              end
            end
            else
            begin
              dcs_fail(`DCS_E_SYNTAX);
            end
          end
        end
        // Discard through the next commit, which is also eaten.
        ST_SKIP:
        begin
          if (take && is_x)
          begin
            state <= ST_IDLE;
            pend <= {`DCS_NSLOT{1'b0}};
          end
        end
        // One slot per cycle in slot order, so step seven's group
        // falls between trigger level and trigger times.
        ST_COMMIT:
        begin
          apply_stb <= pend[idx];
          apply_slot <= idx;
          apply_val <= stg[idx];
          if (idx == `DCS_S_TCFG && pend[idx])
          begin
            acq_en <= 1'b1;
          end
          // The trigger only fires once acquisition is configured.
          if (idx == `DCS_S_TRIG)
          begin
            trig_stb <= pend[idx] & acq_en;
          end
          if (idx == `DCS_S_LAST)
          begin
            state <= ST_IDLE;
            char_ready <= 1'b1;
            pend <= {`DCS_NSLOT{1'b0}};
            ev_commit <= 1'b1;
          end
          else
          begin
            idx <= idx + 5'h01;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          char_ready <= 1'b1;
        end
      endcase
    end
  end

  // Sticky status, enable and interrupt. A new event in the cycle
  // of its clear keeps the bit set, so no event is lost.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      stat <= {`DCS_ST_W{1'b0}};
      ien <= {`DCS_ST_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `DCS_OFF_CLEAR)
      begin
        stat <= (stat & ~reg_wdata[`DCS_ST_W-1:0]) |
          {ev_imm, ev_err, ev_commit};
      end
      else
      begin
        stat <= stat | {ev_imm, ev_err, ev_commit};
      end
      if (reg_wr && reg_addr == `DCS_OFF_ENABLE)
      begin
        ien <= reg_wdata[`DCS_ST_W-1:0];
      end
      irq <= |(stat & ien);
    end
  end

  // Read data stand one cycle after the strobe and are zero
  // otherwise; unmapped offsets and the clear register read zero.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `DCS_OFF_STATUS: reg_rdata <= {29'h00000000, stat};
        `DCS_OFF_ENABLE: reg_rdata <= {29'h00000000, ien};
        `DCS_OFF_ERROR:
          reg_rdata <= {acq_en, 23'h000000, state, err_led, err_code};
        `DCS_OFF_PEND: reg_rdata <= {12'h000, pend};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // dcs_sequencer

// ==== sim/dcs_seq_chk.sv ====
`timescale 1ns/1ps
`include "dcs_regs.vh"

module dcs_seq_chk (
  // Clock and synchronous reset.
  input wire clk,
  input wire rst_n,
  // Character link and register port.
  input wire char_ready,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Commit and immediate results.
  input wire apply_stb,
  input wire [4:0] apply_slot,
  input wire trig_stb,
  input wire acq_en,
  input wire err_led,
  input wire [11:0] imm_cmd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Slot of the previous pulse in the running commit walk.
  reg seen;
  reg [4:0] prev_slot;
  // Cycles that the link has been refused so far.
  reg [4:0] low_cnt;

  // Helper state; a ready link closes the walk, so order is per line.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      seen <= 1'b0;
      prev_slot <= 5'h00;
      low_cnt <= 5'h00;
    end
    else
    begin
      if (apply_stb)
      begin
        seen <= 1'b1;
        prev_slot <= apply_slot;
      end
      else if (char_ready)
        seen <= 1'b0;
      if (char_ready)
        low_cnt <= 5'h00;
      else
        low_cnt <= low_cnt + 5'h01;
    end
  end

  a_apply_in_walk: assert property (
    apply_stb |-> $past(!char_ready))
    else $error("staged effect released outside a commit walk");
  a_slot_order: assert property (
    apply_stb && seen |-> apply_slot > prev_slot)
    else $error("commit slots out of order");
  a_slot_range: assert property (
    apply_stb |-> apply_slot <= `DCS_S_LAST)
    else $error("commit slot beyond the deferred set");
  a_trig_armed: assert property (trig_stb |-> acq_en)
    else $error("trigger issued before acquisition armed");
  a_acq_cause: assert property ($rose(acq_en) |->
    (apply_stb && apply_slot == `DCS_S_TCFG) ||
    ($past(apply_stb) && $past(apply_slot) == `DCS_S_TCFG))
    else $error("acquisition armed without trigger configuration");
  a_acq_hold: assert property (acq_en |=> acq_en)
    else $error("acquisition enable dropped outside reset");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data shown without a read");
  a_err_clear: assert property (
    $fell(err_led) |-> ##[0:1] imm_cmd == 12'h245)
    else $error("error indicator cleared without error query");
  a_walk_len: assert property (
    $rose(char_ready) |-> low_cnt == 5'h14)
    else $error("commit walk length wrong");
endmodule // dcs_seq_chk

bind dcs_sequencer dcs_seq_chk i_dcs_seq_chk (
  .clk(clk),
  .rst_n(rst_n),
  .char_ready(char_ready),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .apply_stb(apply_stb),
  .apply_slot(apply_slot),
  .trig_stb(trig_stb),
  .acq_en(acq_en),
  .err_led(err_led),
  .imm_cmd(imm_cmd)
);

// ==== sim/dcs_host_model.sv ====
`timescale 1ns/1ps

module dcs_host_model (
  // Link clock.
  input wire clk,
  // Character handshake toward the sequencer.
  output reg char_valid,
  output reg [7:0] char_data,
  input wire char_ready
);
  // Idle link at time zero.
  initial
  begin
    char_valid = 1'b0;
    char_data = 8'h00;
  end

  // Offers each character and holds it until an edge takes it.
  // Callers end lines with the execute command; the deferred test sends its X later.
  task automatic send(input string s);
    integer i;
    integer n;
    begin
      @(posedge clk);
      for (i = 0; i < s.len(); i = i + 1)
      begin
        char_valid <= 1'b1;
        char_data <= s[i];
        n = 0;
        @(posedge clk);
        while (!char_ready && n < 100)
        begin
          n = n + 1;
          @(posedge clk);
        end
      end
      // Released data never keeps the last value, so stale reads show.
      char_valid <= 1'b0;
      char_data <= ~char_data;
    end
  endtask
endmodule // dcs_host_model

// ==== sim/dcs_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`include "dcs_regs.vh"

module dcs_sequencer_tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h00000000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire char_valid;
  wire [7:0] char_data;
  wire char_ready, imm_stb, apply_stb, trig_stb, acq_en, err_led, irq;
  wire [11:0] imm_cmd;
  wire [15:0] imm_val, apply_val;
  wire [4:0] apply_slot;
  wire [31:0] reg_rdata;
  integer error_cnt = 0;
  integer checks = 0;
  integer cyc = 0;
  integer trig_cnt = 0;
  // Event logs, filled from the strobes in arrival order.
  logic [20:0] apq[$];
  logic [27:0] imq[$];
  logic [31:0] d;

  // 50 MHz clock.
  initial
  begin
    forever #10 clk = ~clk;
  end

  dcs_host_model i_dcs_host_model (.clk(clk), .char_valid(char_valid),
    .char_data(char_data), .char_ready(char_ready));

  dcs_sequencer i_dcs_sequencer (.clk(clk), .rst_n(rst_n),
    .char_valid(char_valid), .char_data(char_data),
    .char_ready(char_ready), .imm_stb(imm_stb), .imm_cmd(imm_cmd),
    .imm_val(imm_val), .apply_stb(apply_stb), .apply_slot(apply_slot),
    .apply_val(apply_val), .trig_stb(trig_stb), .acq_en(acq_en),
    .err_led(err_led), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  // Records strobes; the hang guard ends a stuck run.
  always @(posedge clk)
  begin
    if (apply_stb === 1'b1)
      apq.push_back({apply_slot, apply_val});
    if (imm_stb === 1'b1)
      imq.push_back({imm_cmd, imm_val});
    if (trig_stb === 1'b1)
      trig_cnt = trig_cnt + 1;
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      give_verdict();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask

  // Read data stand only in the cycle after the strobe.
  task rd(input [7:0] a, output logic [31:0] v);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
    end
  endtask

  // Sends a line and waits, bounded, for the commit walk to end.
  task line(input string s);
    integer n;
    begin
      apq.delete();
      imq.delete();
      i_dcs_host_model.send(s);
      repeat (3) @(posedge clk);
      n = 0;
      while (char_ready !== 1'b1 && n < 60)
      begin
        n = n + 1;
        @(posedge clk);
      end
      repeat (3) @(posedge clk);
    end
  endtask

  task give_verdict;
    begin
      $display("comparisons %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`DCS_OFF_STATUS, d);
    check(d, 32'h00000000);
    rd(`DCS_OFF_ERROR, d);
    check(d, 32'h00000000);
    check({acq_en, err_led, irq}, 3'h0);
    $display("test reset done");
    // Deferred commands stage only; last repeat wins.
    apq.delete();
    i_dcs_host_model.send("F5 f9 L7 v2 ");
    repeat (3) @(posedge clk);
    check(apq.size(), 0);
    rd(`DCS_OFF_PEND, d);
    // The trailing V stays open until a starter or X ends it.
    check(d, 32'h00000024);
    line("X");
    check(apq.size(), 3);
    check(apq[0], {`DCS_S_UTERM, 16'h0002});
    check(apq[1], {`DCS_S_FMT, 16'h0009});
    check(apq[2], {`DCS_S_TLVL, 16'h0007});
    rd(`DCS_OFF_PEND, d);
    check(d, 32'h00000000);
    rd(`DCS_OFF_STATUS, d);
    check(d[`DCS_ST_COMMIT], 1'b1);
    $display("test deferred done");
    // Channel setup group lands in step seven whatever the arrival.
    line("Y3 *c C2 a1 P4 X");
    check(apq.size(), 5);
    check(apq[0], {`DCS_S_ALM, 16'h0001});
    check(apq[1], {`DCS_S_CHCFG, 16'h0002});
    check(apq[2], {`DCS_S_CHCLR, 16'h0000});
    check(apq[3], {`DCS_S_TTIME, 16'h0004});
    check(apq[4], {`DCS_S_COUNT, 16'h0003});
    $display("test channel group done");
    // Lower case immediate acts at once.
    line("k5 X");
    check(imq[0], {12'h04B, 16'h0005});
    check(imq.size(), 1);
    $display("test immediate done");
    // A stray character aborts the rest of the line.
    line("O3 L4 ! T3 K2 X");
    check(imq.size(), 1);
    check(imq[0], {12'h04F, 16'h0003});
    check(apq.size(), 0);
    check(err_led, 1'b1);
    rd(`DCS_OFF_ERROR, d);
    check(d[3:0], `DCS_E_SYNTAX);
    rd(`DCS_OFF_PEND, d);
    check(d, 32'h00000000);
    line("@ t1 X");
    check(apq.size(), 2);
    check(apq[0], {`DCS_S_TCFG, 16'h0001});
    check(apq[1][20:16], `DCS_S_TRIG);
    check(acq_en, 1'b1);
    check(trig_cnt, 1);
    $display("test abort done");
    // Over-range value is a conflict; the query clears the indicator.
    line("I70000 X");
    check(apq.size(), 0);
    rd(`DCS_OFF_ERROR, d);
    check(d[3:0], `DCS_E_CONFLICT);
    check(err_led, 1'b1);
    // A query on another immediate must leave the indicator lit.
    line("K? X");
    check(imq[0], {12'h24B, 16'h0000});
    check(err_led, 1'b1);
    line("E? X");
    check(imq[0], {12'h245, 16'h0004});
    check(err_led, 1'b0);
    $display("test conflict done");
    // Interrupt: clear, enable, mask, read-only and unmapped places.
    wr(`DCS_OFF_CLEAR, 32'h0000000F);
    wr(`DCS_OFF_STATUS, 32'h0000000F);
    rd(`DCS_OFF_STATUS, d);
    check(d, 32'h00000000);
    wr(`DCS_OFF_ENABLE, 32'h00000001);
    rd(`DCS_OFF_ENABLE, d);
    check(d, 32'h00000001);
    check(irq, 1'b0);
    line("V1 X");
    check(irq, 1'b1);
    wr(`DCS_OFF_ENABLE, 32'h00000000);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr(`DCS_OFF_ENABLE, 32'h00000001);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    wr(`DCS_OFF_CLEAR, 32'h00000001);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, d);
    check(d, 32'h00000000);
    $display("test interrupt done");
    give_verdict();
  end
endmodule // dcs_sequencer_tb_top
